/* bench/acs_host_model.sv */
// Host receiver model: takes buffered words and counts what it keeps.
// Assumes it shares the sequencer clock and reset.
`timescale 1ns/1ns
`default_nettype none
module acs_host_model
(
   input wire logic sys_clk_i, // Clock
   input wire logic reset_i, // Reset, high
   input wire logic stall_i, // Hold off acceptance
   input wire logic out_valid_i, // Word valid
   input wire acs_pkg::acs_word_t out_word_i, // Offered word
   output logic out_ready_o, // Ready to accept
   output acs_pkg::acs_word_t last_word_o, // Last word taken
   output int word_count_o, // Words taken
   output int kept_count_o // Words kept for full precision
);
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         out_ready_o <= 1'b0;
         word_count_o <= 0;
         kept_count_o <= 0;
      end
      else
      begin
         out_ready_o <= !stall_i;
         if (out_valid_i && out_ready_o)
         begin
            last_word_o <= out_word_i;
            word_count_o <= word_count_o + 1;
            if (word_count_o >= 2) kept_count_o <= kept_count_o + 1;
         end
      end
   end
endmodule
`default_nettype wire

/* bench/testbench.sv */
// Self-checking bench for the startup and chop sequencer.
// Assumes the host model file is compiled before this one.
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int N = 16;
   localparam int POR = int'(acs_pkg::POR_WAIT_CYC);
   logic sys_clk_i, reset_i, soft_reset_i, sync_n_i, stall, out_ready, out_valid;
   logic data_ready_n, filter_reset, polarity, cal_bypass, dc_block, mod_run, data_ready_n_q;
   acs_pkg::acs_cfg_t cfg;
   acs_pkg::acs_word_t word, last_word;
   logic [23:0] fast_s, sinc_s, rnd;
   int failures, check_count, cyc_cnt, falls, fall_at, resets, words, kept, t1, r, g;
   acs_sequencer DUT (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .soft_reset_i(soft_reset_i),
      .sync_n_i(sync_n_i), .cfg_i(cfg), .fast_sample_i(fast_s), .sinc_sample_i(sinc_s),
      .out_ready_i(out_ready), .out_valid_o(out_valid), .out_word_o(word), .data_ready_n_o(data_ready_n),
      .filter_reset_o(filter_reset), .polarity_o(polarity), .phase_cal_bypass_o(cal_bypass),
      .dc_test_block_o(dc_block), .modulator_run_o(mod_run));
   acs_host_model host (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .stall_i(stall), .out_valid_i(out_valid),
      .out_word_i(word), .out_ready_o(out_ready), .last_word_o(last_word), .word_count_o(words),
      .kept_count_o(kept));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic report_and_stop();
      if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [23:0] lfsr(input logic [23:0] s);
      return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
   endfunction
   function automatic int chop_per(input int code, input int n);
      return (1 << (code + 1)) + 3 * n;
   endfunction
   task automatic new_samples();
      rnd = lfsr(rnd);
      fast_s = rnd;
      rnd = lfsr(rnd);
      sinc_s = rnd;
   endtask
   task automatic wait_until(input int c);
      while (cyc_cnt < c) @(negedge sys_clk_i);
   endtask
   task automatic wait_fall();
      int n;
      n = falls;
      repeat (5000) if (falls == n) @(negedge sys_clk_i);
      check(32'(falls != n), 1);
   endtask
   initial
   begin
      sys_clk_i = 0;
      forever #10 sys_clk_i = !sys_clk_i;
   end
   always @(posedge sys_clk_i)
   begin
      cyc_cnt++;
      if (data_ready_n_q === 1'b1 && data_ready_n === 1'b0)
      begin
         falls++;
         fall_at = cyc_cnt - 1;
      end
      data_ready_n_q <= data_ready_n;
      if (filter_reset === 1'b1) resets++;
      if (cyc_cnt == 60000)
      begin
         failures++;
         report_and_stop();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      reset_i = 1;
      soft_reset_i = 0;
      sync_n_i = 1;
      stall = 0;
      rnd = 24'h00001C;
      cfg = '{chop_enable: 1'b0, chop_delay_select: 4'h0, oversampling_ratio: 24'(N)};
      new_samples();
      repeat (6) @(negedge sys_clk_i);
      reset_i = 0;
      t1 = cyc_cnt;
      wait_until(t1 + POR - 10);
      check(32'(data_ready_n), 0);
      wait_until(t1 + POR + 10);
      check(32'(data_ready_n), 1);
      wait_until(t1 + POR + 290);
      check(32'(mod_run), 0);
      wait_until(t1 + POR + 310);
      check(32'(mod_run), 1);
      wait_fall();
      check(32'(fall_at - t1), 32'(POR + 300 + N));
      for (int i = 0; i < 3; i++)
      begin
         if (i > 0) wait_fall();
         if (i == 2) check(32'(fall_at - t1), 32'(POR + 300 + 3 * N));
         repeat (2) @(negedge sys_clk_i);
         check(32'(last_word), 32'(i < 2 ? {fast_s, 2'b10} : {sinc_s, 2'b00}));
      end
      check(32'(kept), 1);
      repeat (3)
      begin
         wait_fall();
         t1 = fall_at;
         wait_fall();
         check(32'(fall_at - t1), 32'(N));
      end
      stall = 1;
      repeat (6 * N) @(negedge sys_clk_i);
      check(32'(out_valid), 1);
      stall = 0;
      wait_fall();
      repeat (2) @(negedge sys_clk_i);
      check(32'(words), 32'(falls));
      new_samples();
      cfg.chop_enable = 1;
      @(negedge sys_clk_i);
      check(32'({cal_bypass, dc_block}), 3);
      for (int code = 0; code < 3; code++)
      begin
         cfg.chop_delay_select = 4'(code);
         repeat (2) wait_fall();
         t1 = fall_at;
         r = resets;
         g = polarity;
         wait_fall();
         check(32'(fall_at - t1), 32'(chop_per(code, N)));
         check(32'(polarity), 32'(g == 0));
         check(32'(resets - r), 1);
         repeat (2) @(negedge sys_clk_i);
         check(32'(last_word), 32'({sinc_s, 2'b01}));
      end
      sync_n_i = 0;
      t1 = cyc_cnt + 1;
      @(negedge sys_clk_i);
      check(32'(polarity), 0);
      sync_n_i = 1;
      wait_fall();
      check(32'(fall_at - t1), 32'(2 * chop_per(2, N) + 44));
      cfg.oversampling_ratio = 24'h000008;
      t1 = cyc_cnt + 1;
      wait_fall();
      check(32'(fall_at - t1), 32'(2 * chop_per(2, 8) + 44));
      cfg = '{chop_enable: 1'b0, chop_delay_select: 4'h0, oversampling_ratio: 24'(N)};
      new_samples();
      repeat (2) @(negedge sys_clk_i);
      check(32'(cal_bypass), 0);
      soft_reset_i = 1;
      @(negedge sys_clk_i);
      soft_reset_i = 0;
      t1 = cyc_cnt;
      wait_until(t1 + 5);
      check(32'(data_ready_n), 1);
      wait_until(t1 + 290);
      check(32'(mod_run), 0);
      wait_until(t1 + 310);
      check(32'(mod_run), 1);
      wait_fall();
      check(32'(fall_at - t1), 32'(300 + N));
      repeat (2) @(negedge sys_clk_i);
      check(32'(last_word), 32'({fast_s, 2'b10}));
      report_and_stop();
   end
endmodule
`default_nettype wire

/* rtl/acs_pkg.sv */
// Package for the converter startup and chop sequencer.
// Assumes one clock (sys_clk_i, 50 MHz) that stands in for the modulator clock.
package acs_pkg;
   // Modulator period counts
   localparam int unsigned POR_WAIT_US = 10;
   localparam int unsigned CLK_MHZ = 50;
   localparam logic [23:0] POR_WAIT_CYC = 24'(POR_WAIT_US * CLK_MHZ);
   localparam logic [23:0] MOD_WAIT_CYC = 24'(256 + 44);
   localparam logic [23:0] RESTART_EXTRA_CYC = 24'(44);
   localparam logic [1:0] FAST_SAMPLES = 2'h2;
   localparam logic [1:0] SINC_SETTLE = 2'h3;
   localparam logic [23:0] OSR_DEFAULT = 24'h000400;
   localparam int SAMPLE_W = 24;

   typedef enum {ST_POR, ST_WAIT, ST_CONV, ST_CHOP_DLY, ST_CHOP_CONV} acs_state_t;

   typedef struct packed {
      logic [SAMPLE_W-1:0] data;
      logic fast_path;
      logic chopped;
   } acs_word_t;

   typedef struct packed {
      logic chop_enable;
      logic [3:0] chop_delay_select;
      logic [23:0] oversampling_ratio;
   } acs_cfg_t;
endpackage

/* rtl/acs_sequencer.sv */
// Startup, filter hand-over and chop sequencing for a two-channel converter.
// Assumes samples arrive one per conversion end and inputs are synchronous.
//
// Overview of operation
// - After supplies settle and power-on wait, data_ready_n rises high.
// - Modulators wait 300 modulator periods after clock start before sampling.
// - Fast path settles in one period; sinc path needs three.
// - First two outputs from fast filter, then sinc results.
// - Default ratio 1024 gives first sample at 1324, sinc at 3372.
// - Command or pin reset skips power-on wait, then same 300-period startup.
// - Continuous mode converts every ratio periods, falling data_ready_n each.
// - Chop alternates polarity and outputs average of overlapping pairs.
// - Each polarity swap resets filter; three conversions per chopped result.
// - Settling delay after each swap from four-bit select, 2 to 65536.
// - Chop period is delay plus three ratio periods; data_ready_n marks each.
// - In chop mode, sync falling edge or ratio change restarts all channels together.
// - First chopped result takes two intervals plus 44 extra periods.
// - Chop mode bypasses inter-channel phase calibration.
// - DC test signal unavailable while chop mode is enabled.
// - data_ready_n is active low, asserting on new conversion data.
`timescale 1ns/1ns
`default_nettype none
module acs_sequencer
(
   input wire logic sys_clk_i, // System clock
   input wire logic reset_i, // Power-on reset, high
   input wire logic soft_reset_i, // Command or pin reset pulse
   input wire logic sync_n_i, // Sync pin, falling edge restarts in chop mode
   input wire acs_pkg::acs_cfg_t cfg_i, // Mode configuration
   input wire logic [acs_pkg::SAMPLE_W-1:0] fast_sample_i, // Fast filter result
   input wire logic [acs_pkg::SAMPLE_W-1:0] sinc_sample_i, // Sinc filter result
   input wire logic out_ready_i, // Receiver ready
   output logic out_valid_o, // Buffered word valid
   output acs_pkg::acs_word_t out_word_o, // Buffered word
   output logic data_ready_n_o, // Active-low data ready
   output logic filter_reset_o, // Filter reset on swap
   output logic polarity_o, // Input polarity, 1 inverted
   output logic phase_cal_bypass_o, // Phase calibration bypass
   output logic dc_test_block_o, // DC test signal blocked
   output logic modulator_run_o // Modulators sampling
);
   acs_pkg::acs_state_t state_reg;
   logic [23:0] cnt_reg;
   logic [1:0] sample_cnt_reg;
   logic [1:0] conv_cnt_reg;
   logic have_prev_reg;
   logic [acs_pkg::SAMPLE_W-1:0] prev_reg;
   logic sync_reg;
   logic [23:0] osr_reg;
   logic data_ready_n_reg;
   logic push;
   acs_pkg::acs_word_t push_word;
   logic buf_ready;
   logic restart;

   // Chop settle delay in periods: 2 to the n plus one
   function automatic logic [23:0] chop_dly(input logic [3:0] sel);
      chop_dly = 24'h000002 << sel;
   endfunction

   function automatic logic [acs_pkg::SAMPLE_W-1:0] avg(input logic [acs_pkg::SAMPLE_W-1:0] a,
      input logic [acs_pkg::SAMPLE_W-1:0] b);
      logic [acs_pkg::SAMPLE_W:0] s;
      s = {a[acs_pkg::SAMPLE_W-1], a} + {b[acs_pkg::SAMPLE_W-1], b};
      avg = s[acs_pkg::SAMPLE_W:1];
   endfunction

   //------------------------------------------------------------
   // Restart detection
   //------------------------------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         sync_reg <= 1'b1;
         osr_reg <= acs_pkg::OSR_DEFAULT;
      end
      else
      begin
         sync_reg <= sync_n_i;
         osr_reg <= cfg_i.oversampling_ratio;
      end
   end

   assign restart = cfg_i.chop_enable && ((sync_reg && !sync_n_i)
      || (osr_reg != cfg_i.oversampling_ratio));

   //------------------------------------------------------------
   // Sequencer
   //------------------------------------------------------------
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         state_reg <= acs_pkg::ST_POR;
         cnt_reg <= 24'h000000;
         sample_cnt_reg <= 2'h0;
         conv_cnt_reg <= 2'h0;
         polarity_o <= 1'b0;
         filter_reset_o <= 1'b0;
         have_prev_reg <= 1'b0;
         prev_reg <= '0;
      end
      else
      begin
         filter_reset_o <= 1'b0;
         if (soft_reset_i)
         begin
            state_reg <= acs_pkg::ST_WAIT;
            cnt_reg <= 24'h000000;
            sample_cnt_reg <= 2'h0;
            polarity_o <= 1'b0;
            have_prev_reg <= 1'b0;
            filter_reset_o <= 1'b1;
         end
         else if (restart && state_reg != acs_pkg::ST_POR && state_reg != acs_pkg::ST_WAIT)
         begin
            state_reg <= acs_pkg::ST_CHOP_DLY;
            cnt_reg <= 24'h000000 - acs_pkg::RESTART_EXTRA_CYC;
            conv_cnt_reg <= 2'h0;
            have_prev_reg <= 1'b0;
            polarity_o <= 1'b0;
            filter_reset_o <= 1'b1;
         end
         else
         begin
            case (state_reg)
               acs_pkg::ST_POR:
               begin
                  cnt_reg <= cnt_reg + 24'h000001;
                  if (cnt_reg + 24'h000001 >= acs_pkg::POR_WAIT_CYC)
                  begin
                     state_reg <= acs_pkg::ST_WAIT;
                     cnt_reg <= 24'h000000;
                  end
               end
               acs_pkg::ST_WAIT:
               begin
                  cnt_reg <= cnt_reg + 24'h000001;
                  if (cnt_reg + 24'h000001 >= acs_pkg::MOD_WAIT_CYC)
                  begin
                     cnt_reg <= 24'h000000;
                     conv_cnt_reg <= 2'h0;
                     if (cfg_i.chop_enable)
                        state_reg <= acs_pkg::ST_CHOP_DLY;
                     else
                        state_reg <= acs_pkg::ST_CONV;
                  end
               end
               acs_pkg::ST_CONV:
               begin
                  cnt_reg <= cnt_reg + 24'h000001;
                  if (cnt_reg + 24'h000001 >= cfg_i.oversampling_ratio && buf_ready)
                  begin
                     cnt_reg <= 24'h000000;
                     if (sample_cnt_reg != acs_pkg::SINC_SETTLE)
                        sample_cnt_reg <= sample_cnt_reg + 2'h1;
                     if (cfg_i.chop_enable)
                        state_reg <= acs_pkg::ST_CHOP_DLY;
                  end
               end
               acs_pkg::ST_CHOP_DLY:
               begin
                  cnt_reg <= cnt_reg + 24'h000001;
                  if (cnt_reg + 24'h000001 == chop_dly(cfg_i.chop_delay_select))
                  begin
                     cnt_reg <= 24'h000000;
                     conv_cnt_reg <= 2'h0;
                     state_reg <= acs_pkg::ST_CHOP_CONV;
                  end
               end
               acs_pkg::ST_CHOP_CONV:
               begin
                  cnt_reg <= cnt_reg + 24'h000001;
                  if (cnt_reg + 24'h000001 >= cfg_i.oversampling_ratio && buf_ready)
                  begin
                     cnt_reg <= 24'h000000;
                     conv_cnt_reg <= conv_cnt_reg + 2'h1;
                     if (conv_cnt_reg + 2'h1 == acs_pkg::SINC_SETTLE)
                     begin
                        prev_reg <= sinc_sample_i;
                        have_prev_reg <= 1'b1;
                        polarity_o <= !polarity_o;
                        filter_reset_o <= 1'b1;
                        state_reg <= cfg_i.chop_enable ? acs_pkg::ST_CHOP_DLY : acs_pkg::ST_CONV;
                     end
                  end
               end
               default: state_reg <= acs_pkg::ST_POR;
            endcase
         end
      end
   end

   //------------------------------------------------------------
   // Output words
   //------------------------------------------------------------
   always_comb
   begin
      push = 1'b0;
      push_word = '0;
      if (state_reg == acs_pkg::ST_CONV && cnt_reg + 24'h000001 >= cfg_i.oversampling_ratio && buf_ready)
      begin
         push = 1'b1;
         push_word.fast_path = sample_cnt_reg < acs_pkg::FAST_SAMPLES;
         push_word.data = push_word.fast_path ? fast_sample_i : sinc_sample_i;
      end
      else if (state_reg == acs_pkg::ST_CHOP_CONV && cnt_reg + 24'h000001 >= cfg_i.oversampling_ratio
         && buf_ready && conv_cnt_reg + 2'h1 == acs_pkg::SINC_SETTLE && have_prev_reg)
      begin
         push = 1'b1;
         push_word.chopped = 1'b1;
         push_word.data = avg(prev_reg, sinc_sample_i);
      end
   end

   // Data ready: high once out of power-on wait, low one cycle per result
   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
         data_ready_n_reg <= 1'b0;
      else if (state_reg == acs_pkg::ST_POR)
         data_ready_n_reg <= 1'b0;
      else
         data_ready_n_reg <= !push;
   end
   assign data_ready_n_o = data_ready_n_reg;

   assign phase_cal_bypass_o = cfg_i.chop_enable;
   assign dc_test_block_o = cfg_i.chop_enable;
   assign modulator_run_o = state_reg != acs_pkg::ST_POR && state_reg != acs_pkg::ST_WAIT;

   //------------------------------------------------------------
   // Two-entry output buffer
   //------------------------------------------------------------
   acs_pkg::acs_word_t mem_reg [2];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] count_reg;

   assign buf_ready = count_reg != 2'h2 || out_ready_i;
   assign out_valid_o = count_reg != 2'h0;
   assign out_word_o = mem_reg[rd_ptr_reg];

   always_ff @(posedge sys_clk_i)
   begin
      if (reset_i)
      begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
      end
      else
      begin
         if (push)
         begin
            mem_reg[wr_ptr_reg] <= push_word;
            wr_ptr_reg <= !wr_ptr_reg;
         end
         if (out_valid_o && out_ready_i)
            rd_ptr_reg <= !rd_ptr_reg;
         count_reg <= count_reg + {1'b0, push} - {1'b0, out_valid_o && out_ready_i};
      end
   end

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   a_data_ready_n_low_por: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      state_reg == acs_pkg::ST_POR |=> data_ready_n_o == 1'b0)
      else $error("data ready high during power-on wait");
   a_data_ready_n_pulse: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      push && state_reg != acs_pkg::ST_POR |=> !data_ready_n_o) else $error("missing data ready pulse");
   a_fast_first: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      push && !push_word.chopped && sample_cnt_reg >= acs_pkg::FAST_SAMPLES |-> !push_word.fast_path)
      else $error("fast filter used past second sample");
   a_wait_len: assert property (@(posedge sys_clk_i) disable iff (reset_i || soft_reset_i)
      $rose(state_reg == acs_pkg::ST_WAIT) |-> !modulator_run_o [*8]) else $error("modulator started early");
   a_phase_bypass: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      cfg_i.chop_enable |-> phase_cal_bypass_o && dc_test_block_o) else $error("chop bypass missing");
   a_swap_reset: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      $changed(polarity_o) |-> filter_reset_o) else $error("polarity swap without filter reset");
   a_restart_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i || soft_reset_i)
      restart && modulator_run_o |=> state_reg == acs_pkg::ST_CHOP_DLY && !polarity_o)
      else $error("restart ignored");
   a_buf_no_loss: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      count_reg == 2'h2 && !out_ready_i |-> !push) else $error("word pushed into full buffer");
   a_data_ready_n_high_wait: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      state_reg == acs_pkg::ST_WAIT |=> data_ready_n_o) else $error("data ready low during startup wait");
   a_restart_extra: assert property (@(posedge sys_clk_i) disable iff (reset_i || soft_reset_i)
      restart && modulator_run_o |=> cnt_reg == 24'h000000 - acs_pkg::RESTART_EXTRA_CYC)
      else $error("restart extra periods missing");
   a_swap_delay: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      filter_reset_o && cfg_i.chop_enable && modulator_run_o |-> state_reg == acs_pkg::ST_CHOP_DLY)
      else $error("no settling delay after swap");
   a_chop_third: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      push && push_word.chopped |-> conv_cnt_reg == 2'h2 && have_prev_reg)
      else $error("chopped result not on third conversion");
   a_buf_bound: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      count_reg != 2'h3) else $error("buffer count out of range");
endmodule
`default_nettype wire
